// *** hw/load_fault_pkg.sv ***
// Shared constants and types for the load and fault switch controller
package load_fault_pkg;
    localparam int NUM_CH = 14;
    localparam int SEL_W = 8;
    localparam int CODE_W = 2;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INTERVAL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MEASURE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LOAD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LEVELS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_INFO = 8'h20;
    // Field positions
    localparam int CTRL_CHANGE_ONLY = 0;
    localparam int CTRL_SAMPLE_EN = 1;
    localparam int FAULT_TYPE_LSB = 8;
    localparam int LEVELS_FUSE_BIT = 28;
    localparam int IRQ_W = 3;
    localparam int IRQ_REPORT = 0;
    localparam int IRQ_FUSE = 1;
    localparam int IRQ_CONTROL = 2;
    localparam int INTERVAL_W = 16;
    // Reset values
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 16'h0001;
    localparam logic [SEL_W-1:0] SEL_NONE = 8'hFF;
    localparam logic [SEL_W-1:0] LAST_CH = 8'h0D;
    // Level codes
    localparam logic [CODE_W-1:0] LVL_LOW = 2'h0;
    localparam logic [CODE_W-1:0] LVL_HIGH = 2'h1;
    localparam logic [CODE_W-1:0] LVL_OPEN = 2'h2;
    // Fault type codes
    localparam logic [SEL_W-1:0] FT_BATT = 8'h01;
    localparam logic [SEL_W-1:0] FT_GND = 8'h02;
    // Timing: one sample interval unit of 1 ms at 125 MHz
    localparam int UNIT_US = 1000;
    localparam int CLK_MHZ = 125;
    localparam int CYC_PER_UNIT = UNIT_US * CLK_MHZ;
    localparam int UNIT_CNT_W = 17;

    typedef struct packed {
        logic [NUM_CH-1:0] short_batt;
        logic [NUM_CH-1:0] short_gnd;
        logic [NUM_CH-1:0] open_ckt;
        logic [NUM_CH-1:0] measure;
        logic [NUM_CH-1:0] load_b;
    } switch_drive_t;

    typedef struct packed {
        logic fuse;
        logic [NUM_CH*CODE_W-1:0] codes;
    } level_snap_t;

    typedef enum logic {
        MODE_FAULT_SIM,
        MODE_LOAD_SWITCH
    } board_mode_t;
endpackage

// *** hw/pin_sync.sv ***
// Two-stage synchroniser bank for pin inputs
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // pin_sync

// *** hw/load_fault_ctrl.sv ***
// Load switching and fault simulation controller with APB registers
// What this block does
// - Fuse flag reads zero while fuse intact, nonzero once blown.
// - Measure select 0 to 13 routes that channel to measurement.
// - Measure select outside 0 to 13 routes no channel.
// - One threshold status code for each of fourteen channels.
// - Code 0 below low, 1 above high, 2 in between.
// - Fault select 0 to 13 applies the fault to that channel only.
// - Fault select outside 0 to 13 disables fault simulation.
// - Fault type 1 shorts to battery, 2 shorts to ground.
// - Any other fault type opens the selected channel.
// - Load mode steers each channel to one of two loads.
// - Load bit 0 picks first load, 1 picks second load.
// - Every-step setting reports on every sample step.
// - Change-only setting reports only values that changed.
// - Fuse and levels sampled at a millisecond interval set by host.
// - Board runs in one mode; only matching controls take effect.
module load_fault_ctrl
    import load_fault_pkg::*;
#(
    parameter int CYCLES_PER_UNIT = CYC_PER_UNIT
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fuse_blown_pin,
    input wire logic mode_strap_pin,
    input wire logic [NUM_CH-1:0] above_low_pin,
    input wire logic [NUM_CH-1:0] above_high_pin,
    output switch_drive_t drive,
    output logic irq
);
    localparam int SYNC_W = 2 * NUM_CH + 2;

    logic [SYNC_W-1:0] pins_s;
    logic fuse_s;
    logic strap_s;
    logic [NUM_CH-1:0] low_s;
    logic [NUM_CH-1:0] high_s;

    pin_sync #(.WIDTH(SYNC_W)) u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({fuse_blown_pin, mode_strap_pin, above_low_pin, above_high_pin}),
        .sync_out(pins_s)
    );

    assign {fuse_s, strap_s, low_s, high_s} = pins_s;

    // Mode strap caught once, after the synchroniser has settled
    logic [1:0] boot_q;
    logic mode_valid_q;
    board_mode_t mode_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_q <= '0;
            mode_valid_q <= 1'b0;
            mode_q <= MODE_FAULT_SIM;
        end
        else if (!mode_valid_q)
        begin
            boot_q <= boot_q + 2'h1;
            if (boot_q == 2'h3)
            begin
                mode_valid_q <= 1'b1;
                mode_q <= strap_s ? MODE_LOAD_SWITCH : MODE_FAULT_SIM;
            end
        end
    end

    // APB decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_interval = paddr == OFS_INTERVAL;
    wire hit_fault = paddr == OFS_FAULT;
    wire hit_measure = paddr == OFS_MEASURE;
    wire hit_load = paddr == OFS_LOAD;
    wire hit_levels = paddr == OFS_LEVELS;
    wire hit_stat = paddr == OFS_IRQ_STAT;
    wire hit_mask = paddr == OFS_IRQ_MASK;
    wire hit_info = paddr == OFS_INFO;
    wire hit_any = hit_ctrl | hit_interval | hit_fault | hit_measure | hit_load
        | hit_levels | hit_stat | hit_mask | hit_info;

    assign pready = access;
    assign pslverr = access & ~hit_any;

    logic [1:0] ctrl_q;
    logic [INTERVAL_W-1:0] interval_q;
    logic [SEL_W-1:0] fault_ch_q;
    logic [SEL_W-1:0] fault_type_q;
    logic [SEL_W-1:0] meas_sel_q;
    logic [NUM_CH-1:0] load_q;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    level_snap_t snap_q;

    wire change_only = ctrl_q[CTRL_CHANGE_ONLY];
    wire sample_en = ctrl_q[CTRL_SAMPLE_EN];
    wire [SEL_W-1:0] wr_fault_ch = pwdata[SEL_W-1:0];
    wire [SEL_W-1:0] wr_fault_type = pwdata[FAULT_TYPE_LSB +: SEL_W];
    wire [SEL_W-1:0] wr_meas = pwdata[SEL_W-1:0];
    wire [NUM_CH-1:0] wr_load = pwdata[NUM_CH-1:0];

    // controls of the other mode ignored
    wire fault_ctl_ok = mode_valid_q && mode_q == MODE_FAULT_SIM;
    wire load_ctl_ok = mode_valid_q && mode_q == MODE_LOAD_SWITCH;
    wire wr_fault = wr & hit_fault & fault_ctl_ok;
    wire wr_load_en = wr & hit_load & load_ctl_ok;
    wire wr_meas_en = wr & hit_measure;

    // in the change-only setting a control write counts as a transfer only if it changes something
    wire ctl_differs = (wr_fault && {wr_fault_type, wr_fault_ch} != {fault_type_q, fault_ch_q})
        || (wr_meas_en && wr_meas != meas_sel_q)
        || (wr_load_en && wr_load != load_q);
    wire ctl_write = wr_fault | wr_meas_en | wr_load_en;
    wire ctl_event = change_only ? ctl_differs : ctl_write;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RESET;
            interval_q <= INTERVAL_RESET;
            fault_ch_q <= SEL_NONE;
            fault_type_q <= SEL_NONE;
            meas_sel_q <= SEL_NONE;
            load_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            if (wr & hit_ctrl)
                ctrl_q <= pwdata[1:0];
            if (wr & hit_interval)
                interval_q <= pwdata[INTERVAL_W-1:0];
            if (wr_fault)
            begin
                fault_ch_q <= wr_fault_ch;
                fault_type_q <= wr_fault_type;
            end
            if (wr_meas_en)
                meas_sel_q <= wr_meas;
            if (wr_load_en)
                load_q <= wr_load;
            if (wr & hit_mask)
                mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    // level code per channel from the two comparators
    logic [NUM_CH*CODE_W-1:0] codes_now;
    logic [NUM_CH-1:0] meas_d;
    logic [NUM_CH-1:0] fsel_d;

    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
        assign codes_now[ch*CODE_W +: CODE_W] = high_s[ch] ? LVL_HIGH
            : (!low_s[ch] ? LVL_LOW : LVL_OPEN);
        assign meas_d[ch] = meas_sel_q == SEL_W'(ch);
        assign fsel_d[ch] = fault_ch_q == SEL_W'(ch) && fault_ctl_ok;
    end

    wire type_batt = fault_type_q == FT_BATT;
    wire type_gnd = fault_type_q == FT_GND;
    // any other code opens the line
    wire type_open = !type_batt && !type_gnd;

    switch_drive_t drive_d;
    assign drive_d.short_batt = type_batt ? fsel_d : '0;
    assign drive_d.short_gnd = type_gnd ? fsel_d : '0;
    assign drive_d.open_ckt = type_open ? fsel_d : '0;
    assign drive_d.measure = meas_d;
    // load bit set selects the second load
    assign drive_d.load_b = load_ctl_ok ? load_q : '0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            drive <= '0;
        else
            drive <= drive_d;
    end

    logic [UNIT_CNT_W-1:0] unit_cnt_q;
    logic [INTERVAL_W-1:0] step_cnt_q;
    wire unit_tick = unit_cnt_q == UNIT_CNT_W'(CYCLES_PER_UNIT - 1);
    // Interval zero acts as one instead of wrapping to the longest interval
    wire step_due = unit_tick
        && (interval_q == '0 || step_cnt_q >= interval_q - INTERVAL_W'(1));
    wire sample = step_due && sample_en;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unit_cnt_q <= '0;
            step_cnt_q <= '0;
        end
        else
        begin
            unit_cnt_q <= unit_tick ? '0 : unit_cnt_q + UNIT_CNT_W'(1);
            if (unit_tick)
                step_cnt_q <= step_due ? '0 : step_cnt_q + INTERVAL_W'(1);
        end
    end

    level_snap_t snap_now;
    assign snap_now.fuse = fuse_s;
    assign snap_now.codes = codes_now;
    wire snap_differs = snap_now != snap_q;
    // report every step or only on change
    wire report_event = sample && (!change_only || snap_differs);
    wire fuse_event = sample && snap_now.fuse && !snap_q.fuse;

    // fuse flag held in the snapshot
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            snap_q <= '0;
        else if (sample)
            snap_q <= snap_now;
    end

    // Sticky events, set wins over write-one-clear
    wire [IRQ_W-1:0] stat_set = {ctl_event, fuse_event, report_event};
    wire [IRQ_W-1:0] stat_clr = (wr & hit_stat) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~stat_clr) | stat_set;
    end

    assign irq = |(stat_q & mask_q);

    // Read data latched in the setup phase
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        if (hit_ctrl)
            rd_mux[1:0] = ctrl_q;
        if (hit_interval)
            rd_mux[INTERVAL_W-1:0] = interval_q;
        if (hit_fault)
            rd_mux[2*SEL_W-1:0] = {fault_type_q, fault_ch_q};
        if (hit_measure)
            rd_mux[SEL_W-1:0] = meas_sel_q;
        if (hit_load)
            rd_mux[NUM_CH-1:0] = load_q;
        if (hit_levels)
            rd_mux[LEVELS_FUSE_BIT:0] = snap_q;
        if (hit_stat)
            rd_mux[IRQ_W-1:0] = stat_q;
        if (hit_mask)
            rd_mux[IRQ_W-1:0] = mask_q;
        if (hit_info)
            rd_mux[1:0] = {mode_valid_q, mode_q == MODE_LOAD_SWITCH};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= '0;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_meas_none: assert property (
        meas_sel_q > LAST_CH |=> drive.measure == '0)
        else $error("measure route active for out-of-range select");
    a_meas_pick: assert property (
        meas_sel_q <= LAST_CH |=> $onehot(drive.measure)
            && drive.measure[$past(meas_sel_q[3:0])])
        else $error("measure route does not follow select");
    a_fault_off: assert property (
        fault_ch_q > LAST_CH |=> (drive.short_batt | drive.short_gnd | drive.open_ckt) == '0)
        else $error("fault applied with no channel selected");
    a_fault_single: assert property (
        $onehot0(drive.short_batt | drive.short_gnd | drive.open_ckt))
        else $error("fault drive on more than one channel");
    a_short_batt: assert property (
        fault_ctl_ok && fault_ch_q <= LAST_CH && fault_type_q == FT_BATT
            |=> drive.short_batt[$past(fault_ch_q[3:0])] && drive.short_gnd == '0)
        else $error("battery short not applied");
    a_open_line: assert property (
        fault_ctl_ok && fault_ch_q <= LAST_CH && !type_batt && !type_gnd
            |=> drive.open_ckt != '0 && drive.short_batt == '0)
        else $error("open circuit not applied");
    a_load_follow: assert property (
        load_ctl_ok |=> drive.load_b == $past(load_q))
        else $error("load route does not follow load bits");
    a_mode_excl: assert property (
        load_ctl_ok |-> (drive.short_batt | drive.short_gnd | drive.open_ckt) == '0)
        else $error("fault drive active in load mode");
    a_fuse_flag: assert property (
        sample |=> snap_q.fuse == $past(fuse_s))
        else $error("fuse flag not sampled");
    a_change_only: assert property (
        sample && change_only && !snap_differs && !stat_q[IRQ_REPORT]
            |=> !stat_q[IRQ_REPORT])
        else $error("report raised without a change");
    a_every_step: assert property (
        sample && !change_only |=> stat_q[IRQ_REPORT])
        else $error("report missing in every-step setting");
    a_irq_level: assert property (
        (stat_q & mask_q) != '0 |-> irq)
        else $error("interrupt low with unmasked event pending");

    c_report: cover property (sample ##1 stat_q[IRQ_REPORT]);
    c_fuse: cover property (fuse_event);
    c_short_gnd: cover property (drive.short_gnd != '0);
    c_load_b: cover property (drive.load_b != '0);
endmodule // load_fault_ctrl

// *** tb/switch_front_model.sv ***
// Behavioural model of the switch and comparator hardware behind the pins
module switch_front_model
    import load_fault_pkg::*;
(
    input wire switch_drive_t drive,
    input wire logic [NUM_CH*CODE_W-1:0] lvl_set,
    output logic [NUM_CH-1:0] above_low_pin,
    output logic [NUM_CH-1:0] above_high_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CODE_W-1:0] lvl [NUM_CH];
    // Fault paths override the load voltage
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (drive.short_batt[c])
                lvl[c] = LVL_HIGH;
            else if (drive.short_gnd[c])
                lvl[c] = LVL_LOW;
            else if (drive.open_ckt[c])
                lvl[c] = LVL_OPEN;
            else
                lvl[c] = lvl_set[2*c+:2];
        end
    end
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
        begin
            above_high_pin[c] = (lvl[c] == LVL_HIGH);
            above_low_pin[c] = (lvl[c] != LVL_LOW);
        end
    end
endmodule // switch_front_model

// *** tb/testbench.sv ***
// Self-checking bench for the load and fault switch controller
module testbench
    import load_fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ROFS [7] = '{OFS_CTRL, OFS_INTERVAL, OFS_FAULT, OFS_MEASURE,
        OFS_LOAD, OFS_IRQ_MASK, OFS_INFO};
    localparam logic [31:0] RVAL [7] = '{32'h1, 32'h1, 32'hFFFF, 32'hFF, 32'h0, 32'h0, 32'h2};
    localparam logic [7:0] FCH [4] = '{8'h00, 8'h0D, 8'h0E, 8'hFF};
    localparam logic [7:0] FTY [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
    localparam logic [13:0] LDV [4] = '{14'h2A5A, 14'h3FFF, 14'h0000, 14'h15A5};
    logic clk;
    logic rst_n;
    logic psel, penable, pwrite, pready, pslverr, fuse, strap, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_CH-1:0] alow, ahigh;
    logic [NUM_CH*CODE_W-1:0] lvl_set;
    switch_drive_t drive;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;

    load_fault_ctrl #(.CYCLES_PER_UNIT(10)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_blown_pin(fuse),
        .mode_strap_pin(strap), .above_low_pin(alow), .above_high_pin(ahigh),
        .drive(drive), .irq(irq));
    switch_front_model i_front (.drive(drive), .lvl_set(lvl_set),
        .above_low_pin(alow), .above_high_pin(ahigh));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic complete_run();
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t ns: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Waits as long as the slave needs; the watchdog ends a hang
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(80'(rd), 80'(exp));
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        // Let one edge pass so a clear written at the previous edge is seen
        do
        begin
            @(posedge clk);
            n++;
        end
        while (irq !== 1'b1 && n < 100);
        if (irq !== 1'b1)
            mismatches++;
    endtask

    // Reset for 20 cycles, then poll until the strap has been caught
    task automatic boot(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            apb(1'b0, OFS_INFO, 32'h0);
            if (rd[1] === 1'b1)
                break;
        end
    endtask

    initial
    begin
        logic [13:0] oh;
        logic [27:0] lv;
        int t [3];
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fuse = 1'b0;
        strap = 1'b0;
        rst_n = 1'b0;
        lvl_set = '0;
        boot(1'b0);
        chk(80'(drive), 80'h0); // idle switches
        for (int i = 0; i < 7; i++)
            rchk(ROFS[i], RVAL[i]); // reset value
        wr(OFS_INFO, 32'h3);
        rchk(OFS_INFO, 32'h2); // mode is fixed
        apb(1'b0, 8'h24, 32'h0);
        chk(80'({err, rd}), {47'h0, 1'b1, 32'h0}); // unmapped access
        for (int s = 0; s < 16; s++)
        begin
            wr(OFS_MEASURE, (s == 15) ? 32'hFF : 32'(s));
            waitc(2);
            chk(80'(drive.measure), (s < 14) ? 80'(14'h1 << s) : 80'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                oh = (FCH[i] < 8'h0E) ? (14'h1 << FCH[i]) : 14'h0;
                wr(OFS_FAULT, {16'h0, FTY[j], FCH[i]});
                waitc(2);
                chk(80'({drive.short_batt, drive.short_gnd, drive.open_ckt}),
                    80'({(FTY[j] == FT_BATT) ? oh : 14'h0, (FTY[j] == FT_GND) ? oh : 14'h0,
                    (FTY[j] != FT_BATT && FTY[j] != FT_GND) ? oh : 14'h0}));
            end
        end
        wr(OFS_LOAD, 32'h3FFF);
        waitc(2);
        chk(80'(drive.load_b), 80'h0); // load bits ignored
        for (int c = 0; c < NUM_CH; c++)
            lv[2*c+:2] = (c % 3 == 0) ? LVL_LOW : ((c % 3 == 1) ? LVL_HIGH : LVL_OPEN);
        lvl_set <= lv;
        wr(OFS_CTRL, 32'h3); // host picks change-only
        waitc(40);
        rchk(OFS_LEVELS, 32'(lv));
        wr(OFS_IRQ_STAT, 32'h7);
        waitc(40);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(80'(rd[0]), 80'h0); // unchanged snapshot
        lv[1:0] = LVL_HIGH;
        lvl_set <= lv;
        waitc(40);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(80'(rd[0]), 80'h1); // changed snapshot
        fuse <= 1'b1;
        waitc(40);
        rchk(OFS_LEVELS, {4'h1, lv}); // blown fuse
        chk(80'(irq), 80'h0); // masked event
        wr(OFS_IRQ_MASK, 32'h2);
        waitc(1);
        chk(80'(irq), 80'h1); // unmasked event
        wr(OFS_IRQ_STAT, 32'h2);
        waitc(1);
        chk(80'(irq), 80'h0); // event cleared
        fuse <= 1'b0;
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_INTERVAL, 32'h3);
        wr(OFS_CTRL, 32'h2);
        for (int k = 0; k < 3; k++)
        begin
            wait_irq();
            t[k] = cyc;
            wr(OFS_IRQ_STAT, 32'h1);
        end
        chk(80'(t[2] - t[1]), 80'h1E); // report spacing
        wr(OFS_IRQ_MASK, 32'h0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_MEASURE, 32'h5);
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_MEASURE, 32'h5);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(80'(rd[2]), 80'h0); // same control value
        wr(OFS_MEASURE, 32'h6);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(80'(rd[2]), 80'h1); // new control value
        wr(OFS_CTRL, 32'h0);
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_MEASURE, 32'h6);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(80'(rd[2]), 80'h1); // repeated control value
        boot(1'b1);
        rchk(OFS_INFO, 32'h3); // load mode
        chk(80'(drive), 80'h0); // idle switches
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_LOAD, 32'(LDV[i]));
            waitc(2);
            chk(80'(drive.load_b), 80'(LDV[i]));
        end
        wr(OFS_FAULT, 32'h0103);
        waitc(2);
        chk(80'({drive.short_batt, drive.short_gnd, drive.open_ckt}), 80'h0);
        wr(OFS_MEASURE, 32'hD);
        waitc(2);
        chk(80'(drive.measure), 80'h2000); // last channel
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
endmodule // testbench
